// ===== core/psw_bridge_cell.sv
`timescale 1ns/1ns

module psw_bridge_cell
    import psw_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // Mode bits and PWM
    input  wire logic hi_bit_in,
    input  wire logic lo_bit_in,
    input  wire logic pwm_in,
    input  wire logic recirc_in,
    // Protection enables
    input  wire logic en_hi_in,
    input  wire logic en_lo_in,
    // Gate discharged reports, synchronised
    input  wire logic hi_gate_low_in,
    input  wire logic lo_gate_low_in,
    // FET drives
    output logic      hi_out,
    output logic      lo_out
);

    psw_bridge_t st_q;
    psw_bridge_t st_d;
    logic        want_hi;
    logic        want_lo;

    // Mode decode of the two bits
    always_comb begin
        want_hi = hi_bit_in & (~lo_bit_in | pwm_in);
        want_lo = lo_bit_in & (~hi_bit_in | (recirc_in & ~pwm_in));
    end

    // Turn-off is immediate; turn-on waits for the other gate to discharge
    always_comb begin
        st_d    = st_q;
        st_d.hi = want_hi & en_hi_in & ~st_q.lo & lo_gate_low_in;
        st_d.lo = want_lo & en_lo_in & ~st_q.hi & hi_gate_low_in;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign hi_out = st_q.hi;
    assign lo_out = st_q.lo;

    property p_no_shoot;
        @(posedge clk_in) disable iff (reset_in)
        !(st_q.hi && st_q.lo);
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both FETs on");

    property p_bbm_hi;
        @(posedge clk_in) disable iff (reset_in)
        $rose(st_q.hi) |-> $past(lo_gate_low_in) && !$past(st_q.lo);
    endproperty
    a_bbm_hi: assert property (p_bbm_hi) else $error("high on before low off");

endmodule

// ===== core/psw_params.svh
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH

// Register indices; byte address is four times the index
`define PSW_IDX_SW_CTRL   4'h1
`define PSW_IDX_BR_STAT   4'h2
`define PSW_IDX_SYS_CTRL  4'h3
`define PSW_IDX_IRQ_FLAG  4'h4
`define PSW_IDX_IRQ_MASK  4'h5
`define PSW_IDX_HS_OUT    4'h6
`define PSW_IDX_HS_STAT   4'h7
`define PSW_IDX_AMUX_CTRL 4'h8

// Reset value of every register byte
`define PSW_RST_BYTE 8'h00

// Field positions
`define PSW_BR_RECIRC_BIT   7
`define PSW_SYS_POWER_STAGE_ENABLE_BIT    0
`define PSW_SYS_VINH_BIT    1
`define PSW_SYS_HTSEL_LSB   2
`define PSW_IRQ_LV_BIT      0
`define PSW_IRQ_HV_BIT      1
`define PSW_IRQ_HT_BIT      2
`define PSW_HS_PWM_LSB      4
`define PSW_HS_5V_BIT       7
`define PSW_AMUX_GAIN_BIT   0

// Synchroniser depth
`define PSW_SYNC_STAGES 2

`endif

// ===== core/psw_pkg.sv
package psw_pkg;

    // Bus handshake states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } psw_bus_state_t;

    // State of the controller, apart from the bridge cells and the synchroniser
    typedef struct packed {
        psw_bus_state_t bus_st;
        logic [31:0]    rdata;
        logic [7:0]     sw_ctrl;
        logic           recirc;
        logic [3:0]     bridge_oc;
        logic           power_stage_enable;
        logic           vinh;
        logic [1:0]     htsel;
        logic           lv_f;
        logic           hv_f;
        logic           ht_f;
        logic           ht_mask;
        logic           sense_gain;
        logic [2:0]     hs_on;
        logic [2:0]     hs_pwm;
        logic           switched_5v_output_on;
        logic [2:0]     hs_oc;
        logic [2:0]     hs_trip;
        logic [2:0]     hs_drv;
        logic           pwm_prev;
        logic           sw5v;
        logic           hall_en;
        logic           irq;
    } psw_state_t;

    // Gate drive state of one bridge
    typedef struct packed {
        logic hi;
        logic lo;
    } psw_bridge_t;

endpackage

// ===== core/psw_power_switch.sv
`timescale 1ns/1ns
`include "psw_params.svh"

// Summary of operation
// - Reset clears all bridge switch bits so every bridge output is off.
// - Bridge FETs stay off unless the power stage enable bit is set.
// - Switch register holds high and low bit per bridge, bridge four high at bit 7.
// - Bit pair selects off, low on, high on, or high FET in PWM mode.
// - Never both FETs on; turn-on waits for opposite gate discharged.
// - In PWM mode the high FET follows the PWM pin.
// - Recirculation bit turns low FET on while PWM high FET is off; reset clears.
// - Sense gain bit one selects low amplification, zero high amplification.
// - First temperature threshold sets flag; interrupt raised when its mask is set.
// - With temperature shutdown selected, bridge high FETs and high sides are off while flag is set; low FETs are not gated.
// - Temperature flag clears on write of one or reset, not while hot.
// - Without temperature shutdown, second threshold switches off every power stage.
// - Bridge FET over-current switches that FET off and sets bridge flag.
// - Writing one clears bridge over-current flag; zero does nothing; reset clears.
// - Voltage flag with inhibit clear disables bridge outputs.
// - Voltage flags clear on write of one or reset, not while condition stays.
// - Status register: recirculation at bit 7, zeros 6 to 4, flags 3 to 0.
// - High sides stay off unless the power stage enable bit is set.
// - Permanent-on bit holds a high side on, subject to protection.
// - High side PWM bit turns output on while PWM pin is high.
// - Permanent-on only: over-current turns high side off and sets its flag.
// - PWM only: over-current turns off and flags; next PWM rise turns on.
module psw_power_switch
    import psw_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // PWM pin and analog comparators
    input  wire logic        pwm_pin_in,
    input  wire logic [3:0]  hb_hi_oc_in,
    input  wire logic [3:0]  hb_lo_oc_in,
    input  wire logic [2:0]  hs_oc_in,
    input  wire logic        low_voltage_in,
    input  wire logic        high_voltage_in,
    input  wire logic        temp_warn_in,
    input  wire logic        temp_cutoff_in,
    input  wire logic [3:0]  hb_hi_gate_low_in,
    input  wire logic [3:0]  hb_lo_gate_low_in,
    // Power stage drives
    output logic      [3:0]  hb_hi_gate_out,
    output logic      [3:0]  hb_lo_gate_out,
    output logic      [2:0]  hs_on_out,
    output logic             sw5v_en_out,
    output logic             hall_supply_en_out,
    output logic             sense_gain_out,
    output logic             irq_out
);

    localparam int NSYNC = 24;

    psw_state_t       st_q;
    psw_state_t       st_d;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] syn;
    logic             pwm_s;
    logic [3:0]       hb_hi_oc_s;
    logic [3:0]       hb_lo_oc_s;
    logic [2:0]       hs_oc_s;
    logic             lv_s;
    logic             hv_s;
    logic             tw_s;
    logic             tc_s;
    logic [3:0]       hi_gl_s;
    logic [3:0]       lo_gl_s;
    logic             hard_cut;
    logic             ht_shut;
    logic             volt_shut;
    logic [3:0]       en_hi;
    logic [3:0]       en_lo;
    logic             wr;
    logic [3:0]       idx;

    // Register index from a byte address
    function automatic logic [3:0] psw_index(input logic [5:0] addr);
        psw_index = addr[5:2];
    endfunction

    // Every pin level crosses two flops before use
    assign raw = {pwm_pin_in, hb_hi_oc_in, hb_lo_oc_in, hs_oc_in, low_voltage_in,
                  high_voltage_in, temp_warn_in, temp_cutoff_in,
                  hb_hi_gate_low_in, hb_lo_gate_low_in};

    psw_sync #(
        .W (NSYNC)
    ) u_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in (raw),
        .sync_out (syn)
    );

    assign {pwm_s, hb_hi_oc_s, hb_lo_oc_s, hs_oc_s, lv_s, hv_s, tw_s, tc_s,
            hi_gl_s, lo_gl_s} = syn;

    // Protection terms; flags and the live cutoff gate, stored switch bits stay intact
    assign hard_cut  = (st_q.htsel == 2'h0) & tc_s;
    assign ht_shut   = (st_q.htsel != 2'h0) & st_q.ht_f;
    assign volt_shut = (st_q.lv_f | st_q.hv_f) & ~st_q.vinh;

    // Per-bridge enables
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            en_hi[i] = st_q.power_stage_enable & ~hard_cut & ~ht_shut & ~volt_shut
                     & ~st_q.bridge_oc[i] & ~hb_hi_oc_s[i];
            en_lo[i] = st_q.power_stage_enable & ~hard_cut & ~volt_shut
                     & ~st_q.bridge_oc[i] & ~hb_lo_oc_s[i];
        end
    end

    // One cell per bridge, high bit above low bit
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bridge
            psw_bridge_cell u_cell (
                .clk_in         (clk_in),
                .reset_in       (reset_in),
                .hi_bit_in      (st_q.sw_ctrl[2*g+1]),
                .lo_bit_in      (st_q.sw_ctrl[2*g]),
                .pwm_in         (pwm_s),
                .recirc_in      (st_q.recirc),
                .en_hi_in       (en_hi[g]),
                .en_lo_in       (en_lo[g]),
                .hi_gate_low_in (hi_gl_s[g]),
                .lo_gate_low_in (lo_gl_s[g]),
                .hi_out         (hb_hi_gate_out[g]),
                .lo_out         (hb_lo_gate_out[g])
            );
        end
    endgenerate

    // Bus access completes on the edge after the request is seen
    assign idx             = psw_index(avs_address);
    assign wr              = avs_write & (st_q.bus_st == BUS_ACK) & avs_byteenable[0];
    assign avs_waitrequest = (avs_read | avs_write) & (st_q.bus_st != BUS_ACK);

    // Next state of everything
    always_comb begin
        logic [7:0] rbyte;
        logic [7:0] wd;
        logic       hs_ok;
        rbyte = `PSW_RST_BYTE;
        wd    = avs_writedata[7:0];
        hs_ok = st_q.power_stage_enable & ~hard_cut & ~ht_shut & ~volt_shut;
        st_d  = st_q;

        // Read mux; unmapped indices read zero
        case (idx)
            `PSW_IDX_SW_CTRL: begin
                rbyte = st_q.sw_ctrl;
            end
            `PSW_IDX_BR_STAT: begin
                rbyte = {st_q.recirc, 3'h0, st_q.bridge_oc};
            end
            `PSW_IDX_SYS_CTRL: begin
                rbyte[`PSW_SYS_POWER_STAGE_ENABLE_BIT] = st_q.power_stage_enable;
                rbyte[`PSW_SYS_VINH_BIT] = st_q.vinh;
                rbyte[`PSW_SYS_HTSEL_LSB +: 2] = st_q.htsel;
            end
            `PSW_IDX_IRQ_FLAG: begin
                rbyte[`PSW_IRQ_LV_BIT] = st_q.lv_f;
                rbyte[`PSW_IRQ_HV_BIT] = st_q.hv_f;
                rbyte[`PSW_IRQ_HT_BIT] = st_q.ht_f;
            end
            `PSW_IDX_IRQ_MASK: begin
                rbyte[`PSW_IRQ_HT_BIT] = st_q.ht_mask;
            end
            `PSW_IDX_HS_OUT: begin
                rbyte[2:0] = st_q.hs_on;
                rbyte[`PSW_HS_PWM_LSB +: 3] = st_q.hs_pwm;
                rbyte[`PSW_HS_5V_BIT] = st_q.switched_5v_output_on;
            end
            `PSW_IDX_HS_STAT: begin
                rbyte[2:0] = st_q.hs_oc;
            end
            `PSW_IDX_AMUX_CTRL: begin
                rbyte[`PSW_AMUX_GAIN_BIT] = st_q.sense_gain;
            end
            default: begin
                rbyte = `PSW_RST_BYTE;
            end
        endcase

        // Handshake
        case (st_q.bus_st)
            BUS_IDLE: begin
                if (avs_read | avs_write) begin
                    st_d.bus_st = BUS_ACK;
                    st_d.rdata  = {24'h00_0000, rbyte};
                end
            end
            BUS_ACK: begin
                st_d.bus_st = BUS_IDLE;
            end
            default: begin
                st_d.bus_st = BUS_IDLE;
            end
        endcase

        // Plain read/write fields
        if (wr) begin
            case (idx)
                `PSW_IDX_SW_CTRL: begin
                    st_d.sw_ctrl = wd;
                end
                `PSW_IDX_BR_STAT: begin
                    st_d.recirc = wd[`PSW_BR_RECIRC_BIT];
                end
                `PSW_IDX_SYS_CTRL: begin
                    st_d.power_stage_enable  = wd[`PSW_SYS_POWER_STAGE_ENABLE_BIT];
                    st_d.vinh  = wd[`PSW_SYS_VINH_BIT];
                    st_d.htsel = wd[`PSW_SYS_HTSEL_LSB +: 2];
                end
                `PSW_IDX_IRQ_MASK: begin
                    st_d.ht_mask = wd[`PSW_IRQ_HT_BIT];
                end
                `PSW_IDX_HS_OUT: begin
                    st_d.hs_on   = wd[2:0];
                    st_d.hs_pwm  = wd[`PSW_HS_PWM_LSB +: 3];
                    st_d.switched_5v_output_on = wd[`PSW_HS_5V_BIT];
                end
                `PSW_IDX_AMUX_CTRL: begin
                    st_d.sense_gain = wd[`PSW_AMUX_GAIN_BIT];
                end
                default: begin
                    st_d.sw_ctrl = st_q.sw_ctrl;
                end
            endcase
        end

        // Sticky flags: the live condition always wins over a clear
        st_d.bridge_oc = (hb_hi_oc_s | hb_lo_oc_s) | (st_q.bridge_oc
            & ~({4{wr && idx == `PSW_IDX_BR_STAT}} & wd[3:0]));
        st_d.ht_f = tw_s | (st_q.ht_f
            & ~(wr && idx == `PSW_IDX_IRQ_FLAG && wd[`PSW_IRQ_HT_BIT]));
        st_d.lv_f = lv_s | (st_q.lv_f
            & ~(wr && idx == `PSW_IDX_IRQ_FLAG && wd[`PSW_IRQ_LV_BIT]));
        st_d.hv_f = hv_s | (st_q.hv_f
            & ~(wr && idx == `PSW_IDX_IRQ_FLAG && wd[`PSW_IRQ_HV_BIT]));
        st_d.hs_oc = hs_oc_s | (st_q.hs_oc
            & ~({3{wr && idx == `PSW_IDX_HS_STAT}} & wd[2:0]));

        // High sides; trip only matters in PWM-only mode
        st_d.pwm_prev = pwm_s;
        for (int i = 0; i < 3; i++) begin
            if (hs_oc_s[i]) begin
                st_d.hs_trip[i] = 1'b1;
            end else if (pwm_s & ~st_q.pwm_prev) begin
                st_d.hs_trip[i] = 1'b0;
            end
            case ({st_q.hs_pwm[i], st_q.hs_on[i]})
                2'b01: begin
                    st_d.hs_drv[i] = hs_ok & ~st_q.hs_oc[i] & ~hs_oc_s[i];
                end
                2'b10: begin
                    st_d.hs_drv[i] = hs_ok & pwm_s & ~st_d.hs_trip[i];
                end
                2'b11: begin
                    // Inrush mode: current is limited, output stays enabled
                    st_d.hs_drv[i] = hs_ok;
                end
                default: begin
                    st_d.hs_drv[i] = 1'b0;
                end
            endcase
        end

        // Auxiliary supplies and interrupt
        st_d.sw5v    = st_q.power_stage_enable & st_q.switched_5v_output_on & ~hard_cut;
        st_d.hall_en = ~hard_cut;
        st_d.irq     = st_q.ht_f & st_q.ht_mask;
    end

    // Reset clears every register and returns the bus to idle
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q        <= '0;
            st_q.bus_st <= BUS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata       = st_q.rdata;
    assign hs_on_out          = st_q.hs_drv;
    assign sw5v_en_out        = st_q.sw5v;
    assign hall_supply_en_out = st_q.hall_en;
    assign sense_gain_out     = st_q.sense_gain;
    assign irq_out            = st_q.irq;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_pwm_mode0;
        st_q.sw_ctrl[1:0] == 2'b11;
    endsequence

    property p_reset_clear;
        $past(reset_in) |-> st_q.sw_ctrl == 8'h00 && !st_q.recirc;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("switch bits not cleared");

    property p_power_stage_enable_gate;
        !st_q.power_stage_enable |=> hb_hi_gate_out == 4'h0 && hb_lo_gate_out == 4'h0;
    endproperty
    a_power_stage_enable_gate: assert property (p_power_stage_enable_gate) else $error("bridge on without enable");

    property p_pwm_low;
        s_pwm_mode0 and !pwm_s |=> !hb_hi_gate_out[0];
    endproperty
    a_pwm_low: assert property (p_pwm_low) else $error("high FET on with PWM low");

    property p_no_recirc;
        s_pwm_mode0 and !st_q.recirc |=> !hb_lo_gate_out[0];
    endproperty
    a_no_recirc: assert property (p_no_recirc) else $error("low FET on without recirc");

    property p_irq;
        st_q.ht_f && st_q.ht_mask |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("missing interrupt");

    property p_ht_shut;
        st_q.htsel != 2'h0 && st_q.ht_f |=> hb_hi_gate_out == 4'h0 && hs_on_out == 3'h0;
    endproperty
    a_ht_shut: assert property (p_ht_shut) else $error("stage on during shutdown");

    property p_ht_hold;
        tw_s |=> st_q.ht_f;
    endproperty
    a_ht_hold: assert property (p_ht_hold) else $error("temp flag cleared while hot");

    property p_oc_flag;
        hb_lo_oc_s[2] |=> st_q.bridge_oc[2] ##1 !hb_lo_gate_out[2];
    endproperty
    a_oc_flag: assert property (p_oc_flag) else $error("over-current not handled");

    property p_volt;
        (st_q.lv_f || st_q.hv_f) && !st_q.vinh |=> hb_hi_gate_out == 4'h0;
    endproperty
    a_volt: assert property (p_volt) else $error("bridge on in voltage fault");

    property p_hs_power_stage_enable;
        !st_q.power_stage_enable |=> hs_on_out == 3'h0;
    endproperty
    a_hs_power_stage_enable: assert property (p_hs_power_stage_enable) else $error("high side on without enable");

endmodule

// ===== core/psw_sync.sv
`timescale 1ns/1ns
`include "psw_params.svh"

module psw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    // Raw and synchronised levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } psw_sync_t;

    psw_sync_t st_q;
    psw_sync_t st_d;

    // First stage feeds only the second, to settle metastability
    always_comb begin
        st_d    = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.s2;

endmodule

// ===== testbench/psw_power_switch_bench.sv
`timescale 1ns/1ns
module psw_power_switch_bench;
    logic        clk_in, reset_in, avs_read, avs_write, avs_waitrequest, pwm_pin_in;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable, hb_hi_oc_in, hb_lo_oc_in, hb_hi_gate_low_in, hb_lo_gate_low_in;
    logic        low_voltage_in, high_voltage_in, temp_warn_in, temp_cutoff_in;
    logic [2:0]  hs_oc_in, hs_on_out;
    logic [3:0]  hb_hi_gate_out, hb_lo_gate_out;
    logic        sw5v_en_out, hall_supply_en_out, sense_gain_out, irq_out;
    int          fail_count, samples_checked, cycles;

    psw_power_switch u_psw_power_switch (
        .clk_in(clk_in), .reset_in(reset_in), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pwm_pin_in(pwm_pin_in),
        .hb_hi_oc_in(hb_hi_oc_in), .hb_lo_oc_in(hb_lo_oc_in), .hs_oc_in(hs_oc_in),
        .low_voltage_in(low_voltage_in), .high_voltage_in(high_voltage_in),
        .temp_warn_in(temp_warn_in), .temp_cutoff_in(temp_cutoff_in),
        .hb_hi_gate_low_in(hb_hi_gate_low_in), .hb_lo_gate_low_in(hb_lo_gate_low_in),
        .hb_hi_gate_out(hb_hi_gate_out), .hb_lo_gate_out(hb_lo_gate_out),
        .hs_on_out(hs_on_out), .sw5v_en_out(sw5v_en_out),
        .hall_supply_en_out(hall_supply_en_out), .sense_gain_out(sense_gain_out),
        .irq_out(irq_out));

    // 50 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            results();
        end
    end

    task automatic check_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_pin(input string n, input logic [3:0] e, input logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // One bus cycle; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge clk_in);
        avs_address    <= {idx, 2'b00};
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= {24'h00_0000, d};
        avs_byteenable <= be;
        @(posedge clk_in);
        while (avs_waitrequest) begin
            @(posedge clk_in);
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask

    task automatic rdc(input logic [3:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00, 4'h0);
        check_reg($sformatf("register %0d", idx), {24'h00_0000, e}, rd);
    endtask

    // Outputs after sync and drive latency; misc is {5v, hall, gain, irq}
    task automatic chk(input logic [3:0] hi, input logic [3:0] lo, input logic [2:0] hs,
                       input logic [3:0] misc);
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        check_pin("high gates", hi, hb_hi_gate_out);
        check_pin("low gates", lo, hb_lo_gate_out);
        check_pin("high sides", {1'b0, hs}, {1'b0, hs_on_out});
        check_pin("misc", misc, {sw5v_en_out, hall_supply_en_out, sense_gain_out, irq_out});
        @(posedge clk_in);
    endtask

    // Main sequence
    initial begin
        {avs_read, avs_write, pwm_pin_in, low_voltage_in, high_voltage_in} = 5'h00;
        {temp_warn_in, temp_cutoff_in, hb_hi_oc_in, hb_lo_oc_in, hs_oc_in} = 13'h0000;
        {avs_address, avs_writedata, avs_byteenable} = 42'h000_0000_0000;
        hb_hi_gate_low_in = 4'hF;
        hb_lo_gate_low_in = 4'hF;
        {fail_count, samples_checked} = '0;
        reset_in = 1'b1;
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        chk(4'h0, 4'h0, 3'h0, 4'h4);
        for (int i = 0; i < 10; i++)
            rdc(i[3:0], 8'h00);
        wr(4'h9, 8'hFF);
        rdc(4'h9, 8'h00);
        wr(4'h1, 8'h55);
        rdc(4'h1, 8'h55);
        chk(4'h0, 4'h0, 3'h0, 4'h4);
        wr(4'h3, 8'h01);
        chk(4'h0, 4'hF, 3'h0, 4'h4);
        // High turn-on must wait while low gates still report charged
        hb_lo_gate_low_in <= 4'h0;
        wr(4'h1, 8'hAA);
        chk(4'h0, 4'h0, 3'h0, 4'h4);
        hb_lo_gate_low_in <= 4'hF;
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        bus(1'b1, 4'h1, 8'h00, 4'h0);
        rdc(4'h1, 8'hAA);
        // PWM mode with and without recirculation
        wr(4'h1, 8'hFF);
        pwm_pin_in <= 1'b1;
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        pwm_pin_in <= 1'b0;
        chk(4'h0, 4'h0, 3'h0, 4'h4);
        wr(4'h2, 8'hF0);
        rdc(4'h2, 8'h80);
        chk(4'h0, 4'hF, 3'h0, 4'h4);
        pwm_pin_in <= 1'b1;
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        wr(4'h2, 8'h00);
        // Bridge over-current, sticky until a one is written
        wr(4'h1, 8'h55);
        hb_lo_oc_in <= 4'h4;
        chk(4'h0, 4'hB, 3'h0, 4'h4);
        hb_lo_oc_in <= 4'h0;
        wr(4'h2, 8'h00);
        rdc(4'h2, 8'h04);
        rdc(4'h1, 8'h55);
        chk(4'h0, 4'hB, 3'h0, 4'h4);
        wr(4'h2, 8'h04);
        rdc(4'h2, 8'h00);
        chk(4'h0, 4'hF, 3'h0, 4'h4);
        wr(4'h1, 8'hAA);
        hb_hi_oc_in <= 4'h1;
        chk(4'hE, 4'h0, 3'h0, 4'h4);
        hb_hi_oc_in <= 4'h0;
        wr(4'h2, 8'h01);
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        // Voltage flags: clear refused while the condition stands
        low_voltage_in <= 1'b1;
        chk(4'h0, 4'h0, 3'h0, 4'h4);
        wr(4'h4, 8'h01);
        rdc(4'h4, 8'h01);
        low_voltage_in <= 1'b0;
        chk(4'h0, 4'h0, 3'h0, 4'h4);
        wr(4'h4, 8'h01);
        rdc(4'h4, 8'h00);
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        wr(4'h3, 8'h03);
        high_voltage_in <= 1'b1;
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        high_voltage_in <= 1'b0;
        rdc(4'h4, 8'h02);
        wr(4'h4, 8'h02);
        // Temperature warning, interrupt and selectable shutdown
        wr(4'h5, 8'h04);
        temp_warn_in <= 1'b1;
        chk(4'hF, 4'h0, 3'h0, 4'h5);
        rdc(4'h4, 8'h04);
        wr(4'h3, 8'h05);
        chk(4'h0, 4'h0, 3'h0, 4'h5);
        wr(4'h4, 8'h04);
        rdc(4'h4, 8'h04);
        temp_warn_in <= 1'b0;
        chk(4'h0, 4'h0, 3'h0, 4'h5);
        wr(4'h4, 8'h04);
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        wr(4'h3, 8'h01);
        // Hard cutoff takes every stage down
        wr(4'h6, 8'h81);
        chk(4'hF, 4'h0, 3'h1, 4'hC);
        temp_cutoff_in <= 1'b1;
        chk(4'h0, 4'h0, 3'h0, 4'h0);
        temp_cutoff_in <= 1'b0;
        chk(4'hF, 4'h0, 3'h1, 4'hC);
        hs_oc_in <= 3'h1;
        chk(4'hF, 4'h0, 3'h0, 4'hC);
        hs_oc_in <= 3'h0;
        rdc(4'h7, 8'h01);
        wr(4'h7, 8'h01);
        wr(4'h6, 8'h01);
        chk(4'hF, 4'h0, 3'h1, 4'h4);
        wr(4'h3, 8'h00);
        chk(4'h0, 4'h0, 3'h0, 4'h4);
        wr(4'h3, 8'h01);
        // High side PWM with restart on each rising edge
        wr(4'h6, 8'h20);
        pwm_pin_in <= 1'b0;
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        pwm_pin_in <= 1'b1;
        chk(4'hF, 4'h0, 3'h2, 4'h4);
        hs_oc_in <= 3'h2;
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        hs_oc_in <= 3'h0;
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        pwm_pin_in <= 1'b0;
        chk(4'hF, 4'h0, 3'h0, 4'h4);
        pwm_pin_in <= 1'b1;
        chk(4'hF, 4'h0, 3'h2, 4'h4);
        rdc(4'h7, 8'h02);
        wr(4'h8, 8'h01);
        chk(4'hF, 4'h0, 3'h2, 4'h6);
        rdc(4'h8, 8'h01);
        // Both high side bits: inrush limiting keeps the output on, flag still set
        wr(4'h6, 8'h11);
        hs_oc_in <= 3'h1;
        chk(4'hF, 4'h0, 3'h1, 4'h6);
        hs_oc_in <= 3'h0;
        rdc(4'h7, 8'h03);
        // Second reset in mid-run
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        chk(4'h0, 4'h0, 3'h0, 4'h4);
        rdc(4'h1, 8'h00);
        rdc(4'h2, 8'h00);
        results();
    end
endmodule
